/* design/main_stream_attribute_status_bank.sv */
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Read-only bank reporting the timing and format attributes of the first main stream
// Functional notes
// - Horizontal polarity register bit 0 shows the requested horizontal sync polarity.
// - Horizontal sync width register bits 14:0 give pulse width in video clocks.
// - Horizontal start bits 15:0 count clocks from sync edge to active data.
// - Horizontal total bits 15:0 give the full line length in video clocks.
// - Vertical height bits 15:0 give active lines per frame.
// - Vertical polarity bit 0: one is active-high, zero active-low.
// - Vertical sync width bits 14:0 give pulse width in lines.
// - Vertical start bits 15:0 give blanking lines before first active line.
// - Vertical total bits 15:0 give total lines per frame.
// - Misc attribute bits 7:5 give bits per component.
// - Misc bit 4 selects colorimetry: one BT709-5, zero BT601-5.
// - Misc bit 3 selects range: one consumer, zero computer display.
// - Misc bits 2:1 give component format: RGB, 422, 444, reserved.
// - Misc bit 0: zero synchronous clock mode, one asynchronous.
module main_stream_attribute_status_bank
  import msa_status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [addr_w-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic attr_valid,
  input wire logic hsync_polarity_in,
  input wire logic [14:0] hsync_width_in,
  input wire logic [15:0] horizontal_start_in,
  input wire logic [15:0] horizontal_total_in,
  input wire logic [15:0] vertical_active_height_in,
  input wire logic vsync_polarity_in,
  input wire logic [14:0] vsync_width_in,
  input wire logic [15:0] vertical_start_in,
  input wire logic [15:0] vertical_total_in,
  input wire logic [2:0] color_depth_in,
  input wire logic colorimetry_select_in,
  input wire logic range_select_in,
  input wire logic [1:0] component_format_in,
  input wire logic clock_mode_in,
  output logic attr_seen_q
);
  logic hsync_polarity_q;
  logic [14:0] hsync_width_q;
  logic [15:0] horizontal_start_q;
  logic [15:0] horizontal_total_q;
  logic [15:0] vertical_active_height_q;
  logic vsync_polarity_q;
  logic [14:0] vsync_width_q;
  logic [15:0] vertical_start_q;
  logic [15:0] vertical_total_q;
  logic [7:0] misc_attribute_zero_q;
  logic [7:0] misc_in;
  logic [31:0] read_mux;
  logic [31:0] reg_rdata_d;

  // Misc byte packed from its fields
  assign misc_in[color_depth_msb:color_depth_lsb] = color_depth_in;
  assign misc_in[colorimetry_select_bit] = colorimetry_select_in;
  assign misc_in[range_select_bit] = range_select_in;
  assign misc_in[component_format_msb:component_format_lsb] = component_format_in;
  assign misc_in[clock_mode_bit] = clock_mode_in;

  // Whole set loads in one cycle; software reading across a new attr_valid can still see fields of two attribute sets
  msa_field_reg #(.width(1)) u_hspol (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(attr_valid),
    .value(hsync_polarity_in), .field_q(hsync_polarity_q));
  msa_field_reg #(.width(15)) u_hswidth (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(attr_valid),
    .value(hsync_width_in), .field_q(hsync_width_q));
  msa_field_reg #(.width(16)) u_hstart (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(attr_valid),
    .value(horizontal_start_in), .field_q(horizontal_start_q));
  msa_field_reg #(.width(16)) u_htotal (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(attr_valid),
    .value(horizontal_total_in), .field_q(horizontal_total_q));
  msa_field_reg #(.width(16)) u_vheight (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(attr_valid),
    .value(vertical_active_height_in), .field_q(vertical_active_height_q));
  msa_field_reg #(.width(1)) u_vspol (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(attr_valid),
    .value(vsync_polarity_in), .field_q(vsync_polarity_q));
  msa_field_reg #(.width(15)) u_vswidth (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(attr_valid),
    .value(vsync_width_in), .field_q(vsync_width_q));
  msa_field_reg #(.width(16)) u_vstart (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(attr_valid),
    .value(vertical_start_in), .field_q(vertical_start_q));
  msa_field_reg #(.width(16)) u_vtotal (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(attr_valid),
    .value(vertical_total_in), .field_q(vertical_total_q));
  msa_field_reg #(.width(8)) u_misc0 (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(attr_valid),
    .value(misc_in), .field_q(misc_attribute_zero_q));

  // Read decode; reg_wr and reg_wdata are deliberately unused
  assign read_mux =
    (reg_addr == hsync_polarity_off) ? {31'h0000_0000, hsync_polarity_q} :
    (reg_addr == hsync_width_off) ? {17'h0_0000, hsync_width_q} :
    (reg_addr == horizontal_start_off) ? {16'h0000, horizontal_start_q} :
    (reg_addr == horizontal_total_off) ? {16'h0000, horizontal_total_q} :
    (reg_addr == vertical_active_height_off) ? {16'h0000, vertical_active_height_q} :
    (reg_addr == vsync_polarity_off) ? {31'h0000_0000, vsync_polarity_q} :
    (reg_addr == vsync_width_off) ? {17'h0_0000, vsync_width_q} :
    (reg_addr == vertical_start_off) ? {16'h0000, vertical_start_q} :
    (reg_addr == vertical_total_off) ? {16'h0000, vertical_total_q} :
    (reg_addr == misc_attribute_zero_off) ? {24'h00_0000, misc_attribute_zero_q} :
    unmapped_read;
  assign reg_rdata_d = reg_rd ? read_mux : 32'h0000_0000;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
      attr_seen_q <= 1'b0;
    end else begin
      reg_rdata <= reg_rdata_d;
      attr_seen_q <= attr_seen_q | attr_valid;
    end
  end

  // Checks
  a_hspol_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    attr_valid |=> hsync_polarity_q == $past(hsync_polarity_in))
    else $error("hsync polarity not captured");
  a_hswidth_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == hsync_width_off |=> reg_rdata == {17'h0_0000, $past(hsync_width_q)})
    else $error("hsync width read wrong");
  a_htotal_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == horizontal_total_off |=> reg_rdata[31:16] == 16'h0000)
    else $error("htotal upper bits not zero");
  a_vtotal_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    attr_valid |=> vertical_total_q == $past(vertical_total_in))
    else $error("vtotal not captured");
  a_vspol_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == vsync_polarity_off |=> reg_rdata == {31'h0000_0000, $past(vsync_polarity_q)})
    else $error("vsync polarity read wrong");
  a_misc_format: assert property (@(posedge sys_clk) disable iff (sys_rst)
    attr_valid |=> misc_attribute_zero_q[2:1] == $past(component_format_in))
    else $error("component format misplaced");
  a_misc_depth: assert property (@(posedge sys_clk) disable iff (sys_rst)
    attr_valid |=> misc_attribute_zero_q[7:5] == $past(color_depth_in)
      && misc_attribute_zero_q[0] == $past(clock_mode_in))
    else $error("depth or clock mode misplaced");
  a_hold_values: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !attr_valid |=> $stable(horizontal_start_q) && $stable(vertical_start_q))
    else $error("values changed without new attributes");
  a_idle_rdata: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data without read");
  c_attr_load: cover property (@(posedge sys_clk) disable iff (sys_rst) attr_valid);
  c_read_misc: cover property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == misc_attribute_zero_off);
  c_write_ignored: cover property (@(posedge sys_clk) disable iff (sys_rst) reg_wr ##1 reg_rd);
endmodule
`default_nettype wire

/* design/msa_field_reg.sv */
`timescale 1ns/1ps
`default_nettype none
// One captured attribute field, loaded whenever a new attribute set arrives
module msa_field_reg #(
  parameter int width = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [width-1:0] value,
  output logic [width-1:0] field_q
);
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      field_q <= '0;
    end else if (load) begin
      field_q <= value;
    end
  end
endmodule
`default_nettype wire

/* design/msa_status_pkg.sv */
// Package with register map, field layout and reset values of the stream attribute status bank
package msa_status_pkg;
  localparam int addr_w = 12;
  localparam logic [11:0] hsync_polarity_off = 12'h0504;
  localparam logic [11:0] hsync_width_off = 12'h0508;
  localparam logic [11:0] horizontal_start_off = 12'h050C;
  localparam logic [11:0] horizontal_total_off = 12'h0510;
  localparam logic [11:0] vertical_active_height_off = 12'h0514;
  localparam logic [11:0] vsync_polarity_off = 12'h0518;
  localparam logic [11:0] vsync_width_off = 12'h051C;
  localparam logic [11:0] vertical_start_off = 12'h0520;
  localparam logic [11:0] vertical_total_off = 12'h0524;
  localparam logic [11:0] misc_attribute_zero_off = 12'h0528;
  localparam int polarity_bit = 0;
  localparam int sync_width_msb = 14;
  localparam int count_msb = 15;
  localparam int color_depth_msb = 7;
  localparam int color_depth_lsb = 5;
  localparam int colorimetry_select_bit = 4;
  localparam int range_select_bit = 3;
  localparam int component_format_msb = 2;
  localparam int component_format_lsb = 1;
  localparam int clock_mode_bit = 0;
  localparam logic [1:0] format_rgb = 2'h0;
  localparam logic [1:0] format_ycc422 = 2'h1;
  localparam logic [1:0] format_ycc444 = 2'h2;
  localparam logic [1:0] format_reserved = 2'h3;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [7:0] misc_reset = 8'h00;
  localparam logic [31:0] unmapped_read = 32'h0000_0000;
endpackage

/* sim/main_stream_attribute_status_bank_bench.sv */
// Self-checking bench for the stream attribute status bank
`timescale 1ns/1ps
`default_nettype none
module main_stream_attribute_status_bank_bench;
  import msa_status_pkg::*;
  logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, send = 0, attr_valid, attr_seen_q;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [119:0] attr_word = '0, b, w;
  const logic [119:0] a = 120'hF1_2345_6789_ABCD_EF01_3579_BDF2_468A;
  int fails = 0, checks_done = 0, cycles = 0;
  logic [11:0] offs [10] = '{hsync_polarity_off, hsync_width_off, horizontal_start_off, horizontal_total_off,
    vertical_active_height_off, vsync_polarity_off, vsync_width_off, vertical_start_off, vertical_total_off,
    misc_attribute_zero_off};
  always #12.5 sys_clk = ~sys_clk;
  msa_attr_source src (.sys_clk(sys_clk), .send(send), .attr_word(attr_word), .attr_valid(attr_valid), .attr_bus(b));
  main_stream_attribute_status_bank dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .attr_valid(attr_valid),
    .hsync_polarity_in(b[119]), .hsync_width_in(b[118:104]), .horizontal_start_in(b[103:88]),
    .horizontal_total_in(b[87:72]), .vertical_active_height_in(b[71:56]), .vsync_polarity_in(b[55]),
    .vsync_width_in(b[54:40]), .vertical_start_in(b[39:24]), .vertical_total_in(b[23:8]),
    .color_depth_in(b[7:5]), .colorimetry_select_in(b[4]), .range_select_in(b[3]),
    .component_format_in(b[2:1]), .clock_mode_in(b[0]), .attr_seen_q(attr_seen_q));
  function automatic logic [31:0] exp_of(input int k, input logic [119:0] v);
    case (k)
      0: exp_of = {31'h0, v[119]};
      1: exp_of = {17'h0, v[118:104]};
      2: exp_of = {16'h0, v[103:88]};
      3: exp_of = {16'h0, v[87:72]};
      4: exp_of = {16'h0, v[71:56]};
      5: exp_of = {31'h0, v[55]};
      6: exp_of = {17'h0, v[54:40]};
      7: exp_of = {16'h0, v[39:24]};
      8: exp_of = {16'h0, v[23:8]};
      default: exp_of = {24'h0, v[7:0]};
    endcase
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 check($sformatf("read %h", ad), exp, reg_rdata);
  endtask
  task automatic wr(input logic [11:0] ad);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= ad;
    reg_wdata <= 32'hFFFF_FFFF;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task automatic put(input logic [119:0] v);
    @(posedge sys_clk);
    send <= 1;
    attr_word <= v;
    @(posedge sys_clk);
    send <= 0;
  endtask
  task automatic check_all(input logic [119:0] v);
    for (int k = 0; k < 10; k++) rd(offs[k], exp_of(k, v)); // to
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 0;
    check_all('0);
    check("seen idle", 32'h0, {31'h0, attr_seen_q});
    put(a);
    check_all(a);
    check("seen set", 32'h1, {31'h0, attr_seen_q});
    for (int k = 0; k < 10; k++) wr(offs[k]);
    check_all(a);
    // Each pass sets another component format; misc bits 4, 3 and 0 follow the pass index
    for (int i = 0; i < 4; i++) begin
      w = {~a[119:8], 3'(5 - i), i[0], i[1], i[1:0], i[0]};
      put(w);
      check_all(w);
    end
    // Mid-run reset must clear every captured field and the seen flag
    @(posedge sys_clk);
    sys_rst <= 1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
    check_all('0);
    check("seen after reset", 32'h0, {31'h0, attr_seen_q});
    rd(12'h500, unmapped_read);
    rd(12'h52C, unmapped_read);
    end_sim;
  end
endmodule
`default_nettype wire

/* sim/msa_attr_source.sv */
// Behavioural link transmitter that delivers one attribute set per request
`timescale 1ns/1ps
`default_nettype none
module msa_attr_source (
  input wire logic sys_clk,
  input wire logic send,
  input wire logic [119:0] attr_word,
  output var logic attr_valid,
  output logic [119:0] attr_bus
);
  logic [119:0] last_q = '0;
  initial attr_valid = 1'b0;
  // Outside the valid cycle the fields flip, so a capture at the wrong edge shows up
  assign attr_bus = attr_valid ? last_q : ~last_q;
  always @(posedge sys_clk) begin
    attr_valid <= send;
    if (send) begin
      last_q <= attr_word;
    end
  end
endmodule
`default_nettype wire
